//--- hdl/eec_pkg.sv
// package: register map, control fields and timing for the emulated eeprom controller
package eec_pkg;
  // ----------------------------------------
  // register word offsets (byte addresses)
  // ----------------------------------------
  localparam logic [5:0] EEC_OFS_ADDR = 6'h00;
  localparam logic [5:0] EEC_OFS_D0L = 6'h04;
  localparam logic [5:0] EEC_OFS_D0H = 6'h08;
  localparam logic [5:0] EEC_OFS_D1L = 6'h0C;
  localparam logic [5:0] EEC_OFS_D1H = 6'h10;
  localparam logic [5:0] EEC_OFS_D2L = 6'h14;
  localparam logic [5:0] EEC_OFS_D2H = 6'h18;
  localparam logic [5:0] EEC_OFS_D3L = 6'h1C;
  localparam logic [5:0] EEC_OFS_D3H = 6'h20;
  localparam logic [5:0] EEC_OFS_CTRL = 6'h24;
  localparam logic [31:0] EEC_UNMAPPED_READ = 32'h0000_0000;
  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int EEC_BIT_RD_TRIG = 0;
  localparam int EEC_BIT_RD_EN = 1;
  localparam int EEC_BIT_WR_TRIG = 2;
  localparam int EEC_BIT_WR_EN = 3;
  localparam int EEC_BIT_ER_TRIG = 4;
  localparam int EEC_BIT_ER_EN = 5;
  localparam int EEC_BIT_TSEL_LO = 6;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [4:0] EEC_ADDR_RST = 5'h00;
  localparam logic [7:0] EEC_BYTE_RST = 8'h00;
  localparam logic [7:0] EEC_CTRL_RST = 8'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int EEC_CLK_HZ = 20_000_000;
  localparam int EEC_PROG_BASE_MS = 2;
  localparam int EEC_PROG_BASE_CYC = EEC_CLK_HZ / 1000 * EEC_PROG_BASE_MS;
  localparam int EEC_READ_CYC = 4;
  typedef enum logic [1:0] {EEC_IDLE, EEC_ERASE, EEC_WRITE, EEC_READ} eec_state_e;
endpackage

//--- hdl/eec_top.sv
// emulated eeprom controller: register slave, operation sequencer and word array
// Notes on behaviour
// [R1] address holds five bits; upper three read zero
// [R2] four 16-bit data words as low/high byte registers, reset zero
// [R3] time select 00/01/10/11 gives 2/4/8/16 ms erase and write
// [R4] erase enable gates erase and clears itself when erase ends
// [R5] erase trigger starts erase, stays high, cleared at completion
// [R6] erase trigger ignored unless erase enable already set
// [R7] write enable gates writes and clears itself when write ends
// [R8] write trigger starts write, cleared when write finishes
// [R9] write trigger ignored unless write enable already set
// [R10] read enable gates reads and is not self-clearing
// [R11] read trigger starts read, cleared when read finishes
// [R12] read trigger ignored unless read enable already set
// [R13] enable and trigger in one write never start an operation
// [R14] cpu stall output is high while an accepted cycle runs
// [R15] software keeps system clock at least 2 MHz and sub-clock stable
// [R16] erase clears sixteen-word page picked by address bit 4
// [R17] erase trigger counts only in the write right after enable write
// [R18] software masks global interrupt around erase activation
// [R19] erased page words read back as zero
// [R20] software waits for each cycle to finish before other work
// [R21] write stores four words into unit picked by address bits 4..2
// [R22] read places addressed word into data word 0 until next operation
`timescale 1ns/1ps
`default_nettype none
module eec_top
  import eec_pkg::*;
#(
  parameter int P_BASE_CYC = EEC_PROG_BASE_CYC,
  parameter int P_WORDS = 32
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // cpu stall
  output logic o_cpu_stall
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0] mem_reg [P_WORDS];
  logic [4:0] addr_reg;
  logic [7:0] lo_reg [4];
  logic [7:0] hi_reg [4];
  logic [1:0] tsel_reg;
  logic er_en_reg, er_trig_reg, wr_en_reg, wr_trig_reg, rd_en_reg, rd_trig_reg;
  logic er_armed_reg;
  eec_state_e state_reg;
  logic [31:0] cnt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire logic req = (i_avs_read | i_avs_write) & ~ack_reg;
  wire logic wr_go = i_avs_write & ack_reg & i_avs_byteenable[0]; // lands on the answering edge
  wire logic hit_addr = i_avs_address == EEC_OFS_ADDR;
  wire logic hit_ctrl = i_avs_address == EEC_OFS_CTRL;
  wire logic [7:0] wb = i_avs_writedata[7:0];
  wire logic busy = state_reg != EEC_IDLE;
  wire logic ctrl_wr = wr_go & hit_ctrl & ~busy;

  // data register index decode, bit 3 clear (value zero) when not a data register
  function automatic logic [3:0] data_sel(input logic [5:0] a);
    logic [3:0] r;
    r = 4'h0;
    if (a >= EEC_OFS_D0L && a <= EEC_OFS_D3H && a[1:0] == 2'b00) begin
      r = {1'b1, 3'(((a - EEC_OFS_D0L) >> 2))};
    end
    return r;
  endfunction
  wire logic [3:0] dsel = data_sel(i_avs_address);

  // ----------------------------------------
  // operation start qualification
  // ----------------------------------------
  // enable must already be stored; a trigger written alongside its enable is dropped
  wire logic er_start = ctrl_wr & wb[EEC_BIT_ER_TRIG] & er_en_reg & er_armed_reg; // [R6] [R13] [R17]
  wire logic wr_start = ctrl_wr & wb[EEC_BIT_WR_TRIG] & wr_en_reg & ~er_start; // [R9] [R13]
  wire logic rd_start = ctrl_wr & wb[EEC_BIT_RD_TRIG] & rd_en_reg & ~er_start & ~wr_start; // [R12] [R13]
  wire logic [31:0] prog_cyc = 32'(P_BASE_CYC) << tsel_reg; // [R3]
  wire logic done = busy & (cnt_reg == 32'h0000_0001);
  wire logic [2:0] unit = addr_reg[4:2];
  wire logic page = addr_reg[4];

  // ----------------------------------------
  // register bus answer
  // ----------------------------------------
  wire logic [7:0] ctrl_rd = {tsel_reg, er_en_reg, er_trig_reg, wr_en_reg, wr_trig_reg, rd_en_reg, rd_trig_reg};
  logic [31:0] rsel;
  always_comb begin
    rsel = EEC_UNMAPPED_READ;
    if (hit_addr) begin
      rsel = {27'h0, addr_reg}; // [R1]
    end else if (hit_ctrl) begin
      rsel = {24'h0, ctrl_rd};
    end else if (dsel[3]) begin
      rsel = {24'h0, dsel[0] ? hi_reg[dsel[2:1]] : lo_reg[dsel[2:1]]};
    end
  end
  assign o_avs_waitrequest = req;
  assign o_avs_readdata = rdata_reg;
  assign o_cpu_stall = busy; // [R14]

  // one wait state, then answer
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      // only reads refresh the answer, so it stands until the next read
      if (req & i_avs_read) begin
        rdata_reg <= rsel;
      end
    end
  end

  // ----------------------------------------
  // address and data registers
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      addr_reg <= EEC_ADDR_RST;
    end else if (wr_go & hit_addr & ~busy) begin
      addr_reg <= wb[4:0]; // [R1]
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_data
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          lo_reg[g] <= EEC_BYTE_RST; // [R2]
          hi_reg[g] <= EEC_BYTE_RST;
        end else if (g == 0 && done && state_reg == EEC_READ) begin
          lo_reg[g] <= mem_reg[addr_reg][7:0]; // [R22]
          hi_reg[g] <= mem_reg[addr_reg][15:8];
        end else if (wr_go & ~busy & dsel[3] & (dsel[2:1] == 2'(g))) begin
          if (dsel[0]) begin
            hi_reg[g] <= wb;
          end else begin
            lo_reg[g] <= wb;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      {tsel_reg, er_en_reg, er_trig_reg, wr_en_reg, wr_trig_reg, rd_en_reg, rd_trig_reg} <= EEC_CTRL_RST;
      er_armed_reg <= 1'b0;
    end else if (done) begin
      unique case (state_reg)
        EEC_ERASE: begin
          er_trig_reg <= 1'b0; // [R5]
          er_en_reg <= 1'b0; // [R4]
        end
        EEC_WRITE: begin
          wr_trig_reg <= 1'b0; // [R8]
          wr_en_reg <= 1'b0; // [R7]
        end
        EEC_READ: rd_trig_reg <= 1'b0; // [R11] [R10]
        EEC_IDLE: rd_trig_reg <= rd_trig_reg;
      endcase
    end else if (ctrl_wr) begin
      tsel_reg <= wb[7:EEC_BIT_TSEL_LO];
      er_en_reg <= wb[EEC_BIT_ER_EN];
      wr_en_reg <= wb[EEC_BIT_WR_EN];
      rd_en_reg <= wb[EEC_BIT_RD_EN];
      er_trig_reg <= er_start; // [R5] [R6]
      wr_trig_reg <= wr_start; // [R8] [R9]
      rd_trig_reg <= rd_start; // [R11] [R12]
      // arm erase only when this write freshly raised the enable
      er_armed_reg <= wb[EEC_BIT_ER_EN] & ~er_en_reg & ~wb[EEC_BIT_ER_TRIG]; // [R17]
    end else if (wr_go) begin
      er_armed_reg <= 1'b0; // [R17]
    end
  end

  // ----------------------------------------
  // sequencer and array
  // ----------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_reg <= EEC_IDLE;
      cnt_reg <= 32'h0000_0000;
    end else if (done) begin
      state_reg <= EEC_IDLE;
      cnt_reg <= 32'h0000_0000;
    end else if (busy) begin
      cnt_reg <= cnt_reg - 32'h0000_0001;
    end else if (er_start) begin
      state_reg <= EEC_ERASE;
      cnt_reg <= prog_cyc; // [R3]
    end else if (wr_start) begin
      state_reg <= EEC_WRITE;
      cnt_reg <= prog_cyc; // [R3]
    end else if (rd_start) begin
      state_reg <= EEC_READ;
      cnt_reg <= 32'(EEC_READ_CYC);
    end
  end

  generate
    for (g = 0; g < P_WORDS; g++) begin : g_mem
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          mem_reg[g] <= 16'h0000;
        end else if (done && state_reg == EEC_ERASE && (g / 16) == int'(page)) begin
          mem_reg[g] <= 16'h0000; // [R16] [R19]
        end else if (done && state_reg == EEC_WRITE && (g / 4) == int'(unit)) begin
          mem_reg[g] <= {hi_reg[g % 4], lo_reg[g % 4]}; // [R21]
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- tb/eec_checker.sv
// checker: bus answer timing, read data and stall length
`timescale 1ns/1ps
`default_nettype none
module eec_checker
  import eec_pkg::*;
#(
  parameter int P_BASE_CYC = EEC_PROG_BASE_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // register bus
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // stall
  input wire logic o_cpu_stall
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [18:0] run_reg;
  // length of the running stall
  always_ff @(posedge i_mclk) run_reg <= (i_rst || !o_cpu_stall) ? 19'h00000 : run_reg + 19'h00001;
  sequence seq_answer;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  sequence seq_rd_done;
    i_avs_read && !o_avs_waitrequest;
  endsequence
  chk_wait_one: assert property ($rose(i_avs_read || i_avs_write) |-> seq_answer)
    else $error("request not answered one cycle late");
  chk_addr_upper: assert property (seq_rd_done |->
    i_avs_address != EEC_OFS_ADDR || o_avs_readdata[7:5] == 3'h0)
    else $error("address upper bits not zero");
  chk_rd_width: assert property (seq_rd_done |-> o_avs_readdata[31:8] == 24'h000000)
    else $error("read data above byte not zero");
  chk_rd_hold: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data changed without a read");
  chk_reset_quiet: assert property (disable iff (1'b0) i_rst |=> !o_cpu_stall && o_avs_readdata == 32'h0)
    else $error("outputs not cleared by reset");
  chk_stall_cause: assert property ($rose(o_cpu_stall) |-> $past(i_avs_write) || $past(i_avs_write, 2))
    else $error("stall began without a bus write");
  chk_stall_min: assert property ($rose(o_cpu_stall) |-> o_cpu_stall [*4])
    else $error("stall shorter than four cycles");
  chk_stall_bound: assert property (o_cpu_stall |-> run_reg < 8 * P_BASE_CYC)
    else $error("stall longer than longest cycle");
  chk_stall_len: assert property ($fell(o_cpu_stall) |-> run_reg == EEC_READ_CYC || run_reg == P_BASE_CYC ||
    run_reg == 2 * P_BASE_CYC || run_reg == 4 * P_BASE_CYC || run_reg == 8 * P_BASE_CYC)
    else $error("stall length not a legal duration");
endmodule
bind eec_top eec_checker #(.P_BASE_CYC(P_BASE_CYC)) eec_checker_i (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_cpu_stall(o_cpu_stall));
`default_nettype wire

//--- tb/tb_top.sv
// testbench: register access, write, read and erase cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eec_pkg::*;
  localparam int BC = 8;
  logic i_mclk = 0, i_rst = 1, rd = 0, wr = 0;
  logic [5:0] adr = 0;
  logic [31:0] wd = 0, o_avs_readdata;
  logic o_avs_waitrequest, o_cpu_stall;
  logic [7:0] exp_q[$], ts, b, trg[4] = '{8'h01, 8'h04, 8'h10, 8'h04};
  logic [15:0] mem[32];
  logic [4:0] a;
  int error_cnt = 0, total_checks = 0, cyc = 0, scnt = 0;
  eec_top #(.P_BASE_CYC(BC)) eec_top_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_cpu_stall(o_cpu_stall));
  // clock
  initial begin
    forever #25 i_mclk = ~i_mclk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("MISMATCH %0t reads left unanswered", $time);
    end
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // read answers taken at the accepting edge against the oldest note, stall cycles counted
  always @(posedge i_mclk) begin
    if (rd && !o_avs_waitrequest && exp_q.size() > 0) cmp(o_avs_readdata, {24'h0, exp_q.pop_front()});
    if (o_cpu_stall) scnt++;
  end
  // hang guard
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // one bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] ad, input logic [7:0] d);
    @(posedge i_mclk);
    rd <= !w;
    wr <= w;
    adr <= ad;
    wd <= {24'h0, d};
    @(posedge i_mclk);
    while (o_avs_waitrequest) @(posedge i_mclk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdx(input logic [5:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    bus(0, ad, 8'h00);
  endtask
  // clear, enable, then trigger; stall cycles compared with n
  task automatic op(input logic [7:0] t, input logic [7:0] en, input logic [7:0] tr, input int n);
    bus(1, EEC_OFS_CTRL, t);
    bus(1, EEC_OFS_CTRL, t | en);
    scnt = 0;
    bus(1, EEC_OFS_CTRL, t | en | tr);
    repeat (BC * 8 + 8) @(posedge i_mclk);
    cmp(32'(scnt), 32'(n));
  endtask
  task automatic rdw(input logic [4:0] c, input logic [7:0] t);
    bus(1, EEC_OFS_ADDR, {3'h0, c});
    op(t, 8'h02, 8'h01, EEC_READ_CYC);
    rdx(EEC_OFS_D0L, mem[c][7:0]);
    rdx(EEC_OFS_D0H, mem[c][15:8]);
  endtask
  // main sequence
  initial begin
    void'($urandom(32'hff32));
    foreach (mem[i]) mem[i] = 16'h0000;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int k = 0; k < 10; k++) rdx(6'(4 * k), 8'h00);
    rdx(6'h28, 8'h00);
    bus(1, EEC_OFS_ADDR, 8'hFF);
    rdx(EEC_OFS_ADDR, 8'h1F);
    for (int t = 0; t < 4; t++) begin
      ts = 8'(t << 6);
      a = 5'($urandom);
      for (int j = 0; j < 8; j++) begin
        b = 8'($urandom);
        bus(1, 6'(4 * j + 4), b);
        if (j % 2 == 1) mem[{a[4:2], 2'(j / 2)}][15:8] = b;
        else mem[{a[4:2], 2'(j / 2)}][7:0] = b;
      end
      rdx(6'h04, mem[{a[4:2], 2'h0}][7:0]);
      bus(1, EEC_OFS_ADDR, {3'h0, a});
      op(ts, 8'h08, 8'h04, BC << t);
      rdx(EEC_OFS_CTRL, ts);
      rdw(a ^ 5'(t), ts);
      rdx(EEC_OFS_CTRL, ts | 8'h02);
      op(ts, 8'h00, trg[t], 0);
      op(ts, 8'h00, trg[t] | (trg[t] << 1), 0);
    end
    // erase trigger after an unrelated write in between must not start
    bus(1, EEC_OFS_CTRL, 8'h00);
    bus(1, EEC_OFS_CTRL, 8'h20);
    bus(1, EEC_OFS_ADDR, {3'h0, a});
    scnt = 0;
    bus(1, EEC_OFS_CTRL, 8'h30);
    repeat (BC * 8 + 8) @(posedge i_mclk);
    cmp(32'(scnt), 32'h0000_0000);
    rdx(EEC_OFS_CTRL, 8'h20);
    op(8'h00, 8'h20, 8'h10, BC);
    rdx(EEC_OFS_CTRL, 8'h00);
    for (int w = 0; w < 16; w++) mem[{a[4], 4'(w)}] = 16'h0000;
    rdw(a, 8'h00);
    rdw(a ^ 5'h10, 8'h00);
    repeat (2) @(posedge i_mclk);
    complete_run();
  end
endmodule
`default_nettype wire
